// [inc/cpic_pkg.sv]
// shared constants and types for the cascaded priority interrupt controller pair
package cpic_pkg;

   // ==========================================================
   // geometry and register port
   localparam int          NLVL           = 8;
   localparam int          ADDR_W         = 4;
   localparam int          CTL_BIT        = 3;     // address bit that picks master (0) or slave (1)

   // ==========================================================
   // register offsets inside one controller
   localparam logic [2:0]  OFS_MASK       = 3'h0;  // mask_write_word, reads the request_mask_register
   localparam logic [2:0]  OFS_PRIO_EOI   = 3'h1;  // priority_eoi_word, write only
   localparam logic [2:0]  OFS_POLL_SMM   = 3'h2;  // poll_specialmask_word
   localparam logic [2:0]  OFS_VBASE      = 3'h3;  // vector base in bits 7:3
   localparam logic [2:0]  OFS_MODE       = 3'h4;  // init_word_four, master only
   localparam logic [2:0]  OFS_TRIG       = 3'h5;  // trigger_select_master / trigger_select_slave
   localparam logic [2:0]  OFS_REQ        = 3'h6;  // request state, read only
   localparam logic [2:0]  OFS_INSVC      = 3'h7;  // in_service_bits, read only

   // ==========================================================
   // field positions
   localparam int          PE_CMD_LSB     = 5;     // rotate, select-level, service_end_command in 7:5
   localparam int          PS_ENSMM       = 6;     // special_masking_write_enable
   localparam int          PS_SMM         = 5;     // special_masking
   localparam int          PS_POLL        = 2;
   localparam int          MW_AUTOMATIC_SERVICE_END        = 1;     // automatic_service_end
   localparam int          MW_SFNM        = 4;     // special fully nested
   localparam int          POLL_HIT_BIT   = 7;

   // ==========================================================
   // priority word command codes {rotate, select-level, end}
   localparam logic [2:0]  CMD_ROT_AUTO_CLR = 3'h0;
   localparam logic [2:0]  CMD_NS_EOI       = 3'h1;
   localparam logic [2:0]  CMD_NOP          = 3'h2;
   localparam logic [2:0]  CMD_SP_EOI       = 3'h3;
   localparam logic [2:0]  CMD_ROT_AUTO_SET = 3'h4;
   localparam logic [2:0]  CMD_ROT_NS       = 3'h5;
   localparam logic [2:0]  CMD_SET_PRIO     = 3'h6;
   localparam logic [2:0]  CMD_ROT_SP       = 3'h7;

   // ==========================================================
   // cascade and reset values
   localparam logic [2:0]  CASC_INPUT     = 3'h2;
   localparam logic [7:0]  CASC_MASK      = 8'h04;
   localparam logic [2:0]  CASC_SLAVE_CODE = 3'h2;
   localparam logic [2:0]  CASC_IDLE      = 3'h0;
   localparam logic [2:0]  SPURIOUS_LVL   = 3'h7;
   localparam logic [7:0]  TRIG_FIXED_M   = 8'h07;  // inputs 0, 1, 2 stay edge
   localparam logic [7:0]  TRIG_FIXED_S   = 8'h21;  // inputs 8 and 13 stay edge
   localparam logic [2:0]  LOWEST_RST     = 3'h7;   // level 7 lowest gives 0 highest
   localparam logic [16:0] SYNC_RST       = 17'h10000; // acknowledge idles high

   // ==========================================================
   // types
   typedef struct packed {
      logic       hit;
      logic [2:0] lvl;
   } cpic_pick_t;

   typedef struct packed {
      logic [15:0]     inPrev;
      logic [1:0][7:0] edgeLat;
      logic [1:0][7:0] isr;
      logic [1:0][7:0] request_mask_register;
      logic [1:0][7:0] trig;
      logic [1:0][7:0] pollSnap;
      logic [1:0][2:0] lowest;
      logic [1:0][4:0] vbase;
      logic [1:0]      rotAeoi;
      logic [1:0]      special_masking;
      logic [1:0]      pollPend;
      logic            modeAeoi;
      logic            modeSfnm;
      logic            ackPrev;
      logic            ackPhase;
      cpic_pick_t      mPick;
      logic [7:0]      mVec;
      logic [7:0]      sVec;
      logic [2:0]      casc;
      logic            interrupt_output;
      logic [7:0]      vecData;
      logic            vecDrive_b;
      logic [7:0]      rdData;
   } cpic_state_t;

   localparam cpic_state_t ST_RST = '{inPrev: 16'hFFFF, lowest: {2{LOWEST_RST}}, ackPrev: 1'b1,
                                      vecDrive_b: 1'b1, default: '0};

endpackage

// [rtl/cpic_sync.sv]
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module cpic_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_b,
   // pins in, clean levels out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } cpic_sync_t;

   cpic_sync_t st_r;
   cpic_sync_t st_nxt;

   // =================================================
   // width check
   if (W < 1) begin : g_chk
      $error("cpic_sync needs at least one bit");
   end

   // meta stage feeds only the held stage
   always_comb begin
      st_nxt.meta = din;
      st_nxt.held = st_r.meta;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{meta: RST_VAL, held: RST_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.held;
endmodule

// [rtl/cpic_top.sv]
// master and slave priority interrupt controllers with cascade, polling and masking
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - after reset each controller ranks level 0 highest through level 7 lowest
// - acknowledge picks highest request, sends vector, sets in-service until service end
// - in-service level holds off same and lower levels; higher still interrupt
// - special fully nested master lets further slave requests through while slave served
// - on the master, automatic rotation makes an automatically ended level the lowest priority
// - command decode for rotate on end and rotate-in-automatic set and clear
// - set-priority makes given level lowest, next one highest, no service end
// - rotate on specific end clears named level and makes it lowest
// - poll write makes next read of that poll register an acknowledge returning level, requests frozen meanwhile
// - master selects slave by driving code 010 on cascade lines
// - slave winning at master supplies vector in second acknowledge pulse
// - legacy trigger bit unused; per-input trigger selects, edge by default
// - inputs 0, 1, 2, inverted 8 and 13 are always edge triggered
// - edge mode latches only a rising input; staying high asks nothing more
// - level mode requests while high; requester drops it before service end
// - request gone by first acknowledge gives level 7 vector without in-service
// - each mask bit blocks only its own input
// - masking master input 2 blocks every slave request
// - special mask mode: only masked levels blocked, others enabled regardless of service
// - special mask mode entered with enable and mode set, left with enable only
// - in special mask mode non-specific end skips masked in-service levels
// - automatic service end exists on the master only
module cpic_top #(
   parameter logic [2:0] SLAVE_ID = cpic_pkg::CASC_SLAVE_CODE
) (
   // clock and reset
   input  wire logic                        mclk,
   input  wire logic                        rst_b,
   // request pins, bit 8 active low
   input  wire logic [15:0]                 irqPin,
   // processor acknowledge and answer
   input  wire logic                        acknowledgeStrobe_b,
   output logic                             interruptOutput,
   output logic [7:0]                       vectorData,
   output logic                             vectorDrive_b,
   output logic [2:0]                       cascadeCode,
   // register port
   input  wire logic [cpic_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [7:0]                  regWrData,
   input  wire logic                        regWr,
   input  wire logic                        regRd,
   output logic [7:0]                       regRdData
);
   // =================================================
   // elaboration check
   if (SLAVE_ID == cpic_pkg::CASC_IDLE) begin : g_chk
      $error("slave code must differ from the idle cascade code");
   end

   cpic_pkg::cpic_state_t st_r;
   cpic_pkg::cpic_state_t st_nxt;
   logic [16:0]           syncOut;
   logic [15:0]           reqIn;
   logic                  ackS;
   logic                  firstFall;
   logic                  secondFall;
   logic                  trailRise;
   logic [1:0][7:0]       irrEff;
   logic [1:0][7:0]       reqView;
   logic [7:0]            fixedMask;
   logic                  ctl;
   logic [2:0]            ofs;
   logic [2:0]            wrLvl;
   logic [2:0]            mLvlNow;
   cpic_pkg::cpic_pick_t  sPickNow;
   cpic_pkg::cpic_pick_t  mPickNow;

   // =================================================
   // priority helpers
   // walk levels from the one after the lowest, stop at the first blocking in-service bit
   function automatic cpic_pkg::cpic_pick_t resolve(input logic [7:0] req, input logic [7:0] isr,
                                                    input logic [2:0] low, input logic special_masking,
                                                    input logic [7:0] eqOk);
      cpic_pkg::cpic_pick_t p;
      logic                 stop;
      logic [2:0]           l;
      p    = '0;
      stop = 1'b0;
      l    = low;
      for (int k = 0; k < cpic_pkg::NLVL; k++) begin
         l = l + 3'h1;
         if (!stop) begin
            if (req[l] && (special_masking || !isr[l] || eqOk[l])) begin
               p.hit = 1'b1;
               p.lvl = l;
               stop  = 1'b1;
            end else if (isr[l] && !special_masking) begin
               stop = 1'b1;
            end
         end
      end
      return p;
   endfunction

   // highest in-service level in current order, ignoring the skip bits
   function automatic cpic_pkg::cpic_pick_t topIsr(input logic [7:0] isr, input logic [2:0] low,
                                                   input logic [7:0] skip);
      cpic_pkg::cpic_pick_t p;
      logic [2:0]           l;
      p = '0;
      l = low;
      for (int k = 0; k < cpic_pkg::NLVL; k++) begin
         l = l + 3'h1;
         if (!p.hit && isr[l] && !skip[l]) begin
            p.hit = 1'b1;
            p.lvl = l;
         end
      end
      return p;
   endfunction

   // =================================================
   // pin synchronisers
   cpic_sync #(
      .W       (17),
      .RST_VAL (cpic_pkg::SYNC_RST)
   ) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .din   ({acknowledgeStrobe_b, irqPin}),
      .dout  (syncOut)
   );

   // input 8 is active low; flip it so every request is active high
   assign reqIn = {syncOut[15:9], ~syncOut[8], syncOut[7:0]};
   assign ackS  = syncOut[16];

   // acknowledge pulse edges
   assign firstFall  = st_r.ackPrev & ~ackS & ~st_r.ackPhase;
   assign secondFall = st_r.ackPrev & ~ackS & st_r.ackPhase;
   assign trailRise  = ~st_r.ackPrev & ackS & st_r.ackPhase & ~st_r.vecDrive_b;

   // effective requests: level mode follows the pin, edge mode needs a latched rise
   assign irrEff[0] = reqIn[7:0] & (st_r.trig[0] | st_r.edgeLat[0]);
   assign irrEff[1] = reqIn[15:8] & (st_r.trig[1] | st_r.edgeLat[1]);

   // slave output stands in for master input 2
   assign sPickNow   = resolve(irrEff[1] & ~st_r.request_mask_register[1], st_r.isr[1], st_r.lowest[1], st_r.special_masking[1], 8'h00);
   assign reqView[1] = irrEff[1];
   assign reqView[0] = (irrEff[0] & ~cpic_pkg::CASC_MASK) | ({8{sPickNow.hit}} & cpic_pkg::CASC_MASK);
   assign mPickNow   = resolve(reqView[0] & ~st_r.request_mask_register[0], st_r.isr[0], st_r.lowest[0],
                               st_r.special_masking[0], st_r.modeSfnm ? cpic_pkg::CASC_MASK : 8'h00);
   assign mLvlNow    = mPickNow.lvl;

   // register port decode
   assign ctl       = regAddr[cpic_pkg::CTL_BIT];
   assign ofs       = regAddr[2:0];
   assign wrLvl     = regWrData[2:0];
   assign fixedMask = ctl ? cpic_pkg::TRIG_FIXED_S : cpic_pkg::TRIG_FIXED_M;

   // =================================================
   // next state
   // order matters: bus clears first, acknowledge sets next, edge sets last, so sets win
   always_comb begin
      cpic_pkg::cpic_pick_t top;
      cpic_pkg::cpic_pick_t pp;
      logic [2:0]           cmd;
      top         = topIsr(st_r.isr[ctl], st_r.lowest[ctl], st_r.special_masking[ctl] ? st_r.request_mask_register[ctl] : 8'h00);
      pp          = resolve(st_r.pollSnap[ctl] & ~st_r.request_mask_register[ctl], st_r.isr[ctl], st_r.lowest[ctl],
                            st_r.special_masking[ctl], 8'h00);
      cmd         = regWrData[cpic_pkg::PE_CMD_LSB +: 3];
      st_nxt      = st_r;
      st_nxt.rdData = 8'h00;
      st_nxt.ackPrev = ackS;
      st_nxt.interrupt_output    = mPickNow.hit;

      // register writes
      if (regWr) begin
         unique case (ofs)
            cpic_pkg::OFS_MASK: begin
               st_nxt.request_mask_register[ctl] = regWrData;
            end
            cpic_pkg::OFS_PRIO_EOI: begin
               case (cmd)
                  cpic_pkg::CMD_NS_EOI: begin
                     if (top.hit) st_nxt.isr[ctl][top.lvl] = 1'b0;
                  end
                  cpic_pkg::CMD_ROT_NS: begin
                     if (top.hit) begin
                        st_nxt.isr[ctl][top.lvl] = 1'b0;
                        st_nxt.lowest[ctl]       = top.lvl;
                     end
                  end
                  cpic_pkg::CMD_SP_EOI: begin
                     st_nxt.isr[ctl][wrLvl] = 1'b0;
                  end
                  cpic_pkg::CMD_ROT_SP: begin
                     st_nxt.isr[ctl][wrLvl] = 1'b0;
                     st_nxt.lowest[ctl]     = wrLvl;
                  end
                  cpic_pkg::CMD_SET_PRIO: begin
                     st_nxt.lowest[ctl] = wrLvl;
                  end
                  cpic_pkg::CMD_ROT_AUTO_SET: begin
                     st_nxt.rotAeoi[ctl] = 1'b1;
                  end
                  cpic_pkg::CMD_ROT_AUTO_CLR: begin
                     st_nxt.rotAeoi[ctl] = 1'b0;
                  end
                  default: begin
                  end
               endcase
            end
            cpic_pkg::OFS_POLL_SMM: begin
               if (regWrData[cpic_pkg::PS_ENSMM]) begin
                  st_nxt.special_masking[ctl] = regWrData[cpic_pkg::PS_SMM];
               end
               if (regWrData[cpic_pkg::PS_POLL]) begin
                  st_nxt.pollPend[ctl] = 1'b1;
                  st_nxt.pollSnap[ctl] = reqView[ctl];
               end
            end
            cpic_pkg::OFS_VBASE: begin
               st_nxt.vbase[ctl] = regWrData[7:3];
            end
            cpic_pkg::OFS_MODE: begin
               // slave has no automatic end or nesting options
               if (!ctl) begin
                  st_nxt.modeAeoi = regWrData[cpic_pkg::MW_AUTOMATIC_SERVICE_END];
                  st_nxt.modeSfnm = regWrData[cpic_pkg::MW_SFNM];
               end
            end
            cpic_pkg::OFS_TRIG: begin
               st_nxt.trig[ctl] = regWrData & ~fixedMask;
            end
            cpic_pkg::OFS_REQ, cpic_pkg::OFS_INSVC: begin
            end
         endcase
      end

      // register reads, data in the next cycle only
      if (regRd) begin
         unique case (ofs)
            cpic_pkg::OFS_MASK:     st_nxt.rdData = st_r.request_mask_register[ctl];
            cpic_pkg::OFS_PRIO_EOI: st_nxt.rdData = 8'h00;
            cpic_pkg::OFS_POLL_SMM: begin
               if (st_r.pollPend[ctl]) begin
                  // polled read acts as an acknowledge on the frozen snapshot
                  st_nxt.pollPend[ctl] = 1'b0;
                  st_nxt.rdData        = {pp.hit, 4'h0, pp.lvl};
                  if (pp.hit) begin
                     st_nxt.isr[ctl][pp.lvl]     = 1'b1;
                     st_nxt.edgeLat[ctl][pp.lvl] = 1'b0;
                  end
               end else begin
                  st_nxt.rdData = 8'h00;
                  st_nxt.rdData[cpic_pkg::PS_SMM] = st_r.special_masking[ctl];
               end
            end
            cpic_pkg::OFS_VBASE: st_nxt.rdData = {st_r.vbase[ctl], 3'h0};
            cpic_pkg::OFS_MODE: begin
               st_nxt.rdData = 8'h00;
               if (!ctl) begin
                  st_nxt.rdData[cpic_pkg::MW_AUTOMATIC_SERVICE_END] = st_r.modeAeoi;
                  st_nxt.rdData[cpic_pkg::MW_SFNM] = st_r.modeSfnm;
               end
            end
            cpic_pkg::OFS_TRIG:  st_nxt.rdData = st_r.trig[ctl];
            cpic_pkg::OFS_REQ:   st_nxt.rdData = reqView[ctl];
            cpic_pkg::OFS_INSVC: st_nxt.rdData = st_r.isr[ctl];
         endcase
      end

      // first acknowledge pulse: master resolves, slave resolves when it won input 2
      if (firstFall) begin
         st_nxt.ackPhase = 1'b1;
         st_nxt.mPick    = mPickNow;
         st_nxt.mVec     = {st_r.vbase[0], mPickNow.hit ? mPickNow.lvl : cpic_pkg::SPURIOUS_LVL};
         if (mPickNow.hit) begin
            st_nxt.isr[0][mPickNow.lvl]     = 1'b1;
            st_nxt.edgeLat[0][mPickNow.lvl] = 1'b0;
            if (mPickNow.lvl == cpic_pkg::CASC_INPUT) begin
               st_nxt.casc = SLAVE_ID;
               st_nxt.sVec = {st_r.vbase[1], sPickNow.hit ? sPickNow.lvl : cpic_pkg::SPURIOUS_LVL};
               if (sPickNow.hit) begin
                  st_nxt.isr[1][sPickNow.lvl]     = 1'b1;
                  st_nxt.edgeLat[1][sPickNow.lvl] = 1'b0;
               end
            end
         end
      end

      // second pulse: the selected controller drives its vector
      if (secondFall) begin
         st_nxt.vecDrive_b = 1'b0;
         st_nxt.vecData    = (st_r.casc == SLAVE_ID) ? st_r.sVec : st_r.mVec;
      end

      // trailing edge of the second pulse ends the sequence
      if (trailRise) begin
         st_nxt.vecDrive_b = 1'b1;
         st_nxt.ackPhase   = 1'b0;
         st_nxt.casc       = cpic_pkg::CASC_IDLE;
         if (st_r.modeAeoi && st_r.mPick.hit) begin
            st_nxt.isr[0][st_r.mPick.lvl] = 1'b0;
            if (st_r.rotAeoi[0]) begin
               st_nxt.lowest[0] = st_r.mPick.lvl;
            end
         end
      end

      // edge capture last so a rise in the clearing cycle is kept
      st_nxt.inPrev = reqIn;
      for (int i = 0; i < 16; i++) begin
         if (!reqIn[i]) begin
            st_nxt.edgeLat[i / 8][i % 8] = 1'b0;
         end else if (!st_r.inPrev[i]) begin
            st_nxt.edgeLat[i / 8][i % 8] = 1'b1;
         end
      end
   end

   // state register, reset to fixed order and edge triggering
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= cpic_pkg::ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state
   assign interruptOutput = st_r.interrupt_output;
   assign vectorData      = st_r.vecData;
   assign vectorDrive_b   = st_r.vecDrive_b;
   assign cascadeCode     = st_r.casc;
   assign regRdData       = st_r.rdData;

   // =================================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   chk_mask_blocks_all: assert property (st_r.request_mask_register[0] == 8'hFF |=> !interruptOutput)
      else $error("interrupt raised with every master input masked");
   chk_fixed_edge_bits: assert property (((st_r.trig[0] & cpic_pkg::TRIG_FIXED_M) == 8'h00)
                                         && ((st_r.trig[1] & cpic_pkg::TRIG_FIXED_S) == 8'h00))
      else $error("fixed edge input switched to level");
   chk_cascade_select: assert property ((firstFall && mPickNow.hit && mLvlNow == cpic_pkg::CASC_INPUT)
                                        |=> cascadeCode == SLAVE_ID)
      else $error("slave not selected on cascade lines");
   chk_cascade_masked: assert property ((firstFall && st_r.request_mask_register[0][cpic_pkg::CASC_INPUT])
                                        |=> cascadeCode != SLAVE_ID)
      else $error("slave selected while master input 2 masked");
   chk_insvc_set: assert property ((firstFall && mPickNow.hit) |=> st_r.isr[0][$past(mLvlNow)])
      else $error("in-service bit not set on acknowledge");
   chk_spurious_vec: assert property ((secondFall && !st_r.mPick.hit)
                                      |=> vectorData[2:0] == cpic_pkg::SPURIOUS_LVL && !vectorDrive_b)
      else $error("spurious acknowledge did not give level 7 vector");
   chk_slave_vector: assert property ((secondFall && cascadeCode == SLAVE_ID)
                                      |=> vectorData == $past(st_r.sVec) && !vectorDrive_b)
      else $error("slave vector not driven in second pulse");
   chk_set_prio_low: assert property ((regWr && !ctl && ofs == cpic_pkg::OFS_PRIO_EOI
                                       && regWrData[cpic_pkg::PE_CMD_LSB +: 3] == cpic_pkg::CMD_SET_PRIO)
                                      |=> st_r.lowest[0] == $past(wrLvl))
      else $error("set priority did not move lowest level");
   chk_smm_enter: assert property ((regWr && ofs == cpic_pkg::OFS_POLL_SMM && regWrData[cpic_pkg::PS_ENSMM])
                                   |=> st_r.special_masking[$past(ctl)] == $past(regWrData[cpic_pkg::PS_SMM]))
      else $error("special mask mode not updated");
   chk_slave_no_automatic_service_end: assert property ((trailRise && !regWr && !regRd)
                                       |=> st_r.isr[1] == $past(st_r.isr[1]))
      else $error("slave in-service cleared at end of acknowledge");
endmodule

// [sim/cpic_cpu_model.sv]
// processor model issuing two-pulse acknowledges
`timescale 1ns/1ps
module cpic_cpu_model (
   // clock and start
   input  wire logic       mclk,
   input  wire logic       go,
   // acknowledge link
   input  wire logic [7:0] vectorData,
   input  wire logic       vectorDrive_b,
   input  wire logic [2:0] cascadeCode,
   output logic            acknowledgeStrobe_b = 1'b1,
   output logic [7:0]      vecSeen = 8'h00,
   output logic [2:0]      cascSeen = 3'h0,
   output logic            done = 1'b0
);
   // each level lasts 5 cycles, above the 3-cycle minimum
   // seen values cleared per sequence so a missing vector cannot pass on a stale one
   initial forever begin
      @(posedge mclk);
      if (go) begin
         done     <= 1'b0;
         vecSeen  <= 8'h00;
         cascSeen <= 3'h0;
         for (int i = 0; i < 20; i++) begin
            acknowledgeStrobe_b <= !(i < 5 || (i >= 10 && i < 15));
            if (vectorDrive_b === 1'b0) begin
               vecSeen  <= vectorData;
               cascSeen <= cascadeCode;
            end
            @(posedge mclk);
         end
         done <= 1'b1;
      end
   end
endmodule

// [sim/tb.sv]
// self-checking bench for the interrupt controller pair
`timescale 1ns/1ps
module tb;
   logic        mclk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, go = 1'b0;
   logic [15:0] irqPin = 16'h0100;
   logic [3:0]  regAddr = 4'h0;
   logic [7:0]  regWrData = 8'h00;
   logic        ackN, intOut, drvN, done;
   logic [7:0]  vec, rdData, vecSeen;
   logic [2:0]  casc, cascSeen;
   int          fails = 0, numChecks = 0;
   always #12.5 mclk = ~mclk;
   cpic_top DUT (.mclk(mclk), .rst_b(rst_b), .irqPin(irqPin), .acknowledgeStrobe_b(ackN),
      .interruptOutput(intOut), .vectorData(vec), .vectorDrive_b(drvN), .cascadeCode(casc),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(rdData));
   cpic_cpu_model cpu (.mclk(mclk), .go(go), .vectorData(vec), .vectorDrive_b(drvN), .cascadeCode(casc),
      .acknowledgeStrobe_b(ackN), .vecSeen(vecSeen), .cascSeen(cascSeen), .done(done));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      numChecks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      if (fails == 0 && numChecks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe; taken at the edge closing that cycle
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      @(posedge mclk);
      check(rdData, exp);
   endtask
   // bounded wait: a stuck acknowledge ends the run
   task automatic ack(input logic [7:0] exp);
      @(posedge mclk);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(posedge mclk);
         if (done === 1'b1) break;
      end
      if (done !== 1'b1) begin
         fails++;
         summarize();
      end else begin
         check(vecSeen, exp);
      end
   endtask
   // nesting: fixed order, higher level breaks in, non-specific ends
   task automatic t_nesting();
      wr(4'h3, 8'h40);
      irqPin <= 16'h0128;
      repeat (5) @(posedge mclk);
      check({7'h0, intOut}, 8'h01);
      ack(8'h43);
      check({5'h0, cascSeen}, 8'h00);
      rd(4'h7, 8'h08);
      check({7'h0, intOut}, 8'h00);
      irqPin <= 16'h012A;
      repeat (5) @(posedge mclk);
      check({7'h0, intOut}, 8'h01);
      ack(8'h41);
      wr(4'h1, 8'h20);
      rd(4'h7, 8'h08);
      wr(4'h1, 8'h20);
      ack(8'h45);
      wr(4'h1, 8'h20);
   endtask
   // specific priority and rotation, then an acknowledge with nothing pending
   task automatic t_rotation();
      irqPin <= 16'h0100;
      wr(4'h1, 8'hC3);
      irqPin <= 16'h0112;
      repeat (5) @(posedge mclk);
      ack(8'h44);
      wr(4'h1, 8'hE4);
      rd(4'h7, 8'h00);
      ack(8'h41);
      wr(4'h1, 8'h20);
      irqPin <= 16'h0100;
      repeat (5) @(posedge mclk);
      ack(8'h47);
      rd(4'h7, 8'h00);
   endtask
   // slave through master input 2 with special nesting; software ends slave first
   task automatic t_slave();
      wr(4'hB, 8'h70);
      wr(4'h4, 8'h10);
      irqPin <= 16'h1100;
      repeat (5) @(posedge mclk);
      ack(8'h74);
      check({5'h0, cascSeen}, 8'h02);
      irqPin <= 16'h1300;
      repeat (5) @(posedge mclk);
      check({7'h0, intOut}, 8'h01);
      ack(8'h71);
      wr(4'h9, 8'h20);
      rd(4'hF, 8'h10);
      wr(4'h9, 8'h20);
      rd(4'hF, 8'h00);
      wr(4'h1, 8'h20);
      rd(4'h7, 8'h00);
   endtask
   // masking hits its own level only, master input 2 hides the slave; then a poll
   task automatic t_mask_poll();
      wr(4'h0, 8'h0C);
      irqPin <= 16'h0508;
      repeat (5) @(posedge mclk);
      check({7'h0, intOut}, 8'h00);
      rd(4'h0, 8'h0C);
      rd(4'hE, 8'h04);
      ack(8'h47);
      check({5'h0, cascSeen}, 8'h00);
      wr(4'h0, 8'h04);
      wr(4'h2, 8'h04);
      rd(4'h2, 8'h83);
      rd(4'h7, 8'h08);
   endtask
   // special mask mode lets a lower level past the one in service; fixed trigger bits
   task automatic t_smm_trig();
      wr(4'h2, 8'h60);
      rd(4'h2, 8'h20);
      irqPin <= 16'h0518;
      repeat (5) @(posedge mclk);
      check({7'h0, intOut}, 8'h01);
      wr(4'h0, 8'h0C);
      wr(4'h1, 8'h20);
      rd(4'h7, 8'h08);
      wr(4'h2, 8'h40);
      rd(4'h2, 8'h00);
      wr(4'h5, 8'hFF);
      rd(4'h5, 8'hF8);
      wr(4'hD, 8'hFF);
      rd(4'hD, 8'hDE);
   endtask
   // main sequence: reset, then each scenario in turn
   initial begin
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      rd(4'h0, 8'h00);
      rd(4'h7, 8'h00);
      t_nesting();
      t_rotation();
      t_slave();
      t_mask_poll();
      t_smm_trig();
      summarize();
   end
endmodule
